// ==== hdl/rx_status_defs.svh ====
// Register offsets, field positions, reset values and counts for the receiver status bank.
`ifndef RX_STATUS_DEFS_SVH
`define RX_STATUS_DEFS_SVH
// ==================================================
// Register offsets on the control port
`define FAULT_FLAGS_ADDR 7'h10
`define FAULT_ENABLES_ADDR 7'h11
`define STATUS_BUF_CTRL_ADDR 7'h12
`define USER_BUF_CTRL_ADDR 7'h13
`define SUBCODE_FIRST_ADDR 7'h14
`define SUBCODE_LAST_ADDR 7'h1D
`define RATE_RATIO_ADDR 7'h1E
// ==================================================
// Field positions in the fault flag and enable registers
`define FLT_ODD_EVEN 0
`define FLT_LINE_CODE 1
`define FLT_TRUST 2
`define FLT_INVALID 3
`define FLT_LOCK_LOSS 4
`define FLT_STATUS_CRC 5
`define FLT_SUBCODE_CRC 6
// Fault bits that may touch the audio sample; the two CRC bits never do.
`define FLT_SAMPLE_MASK 8'h1F
// Writable bits of the enable register and valid bits of the flag register; the rest read as zero.
`define FLT_WRITE_MASK 8'h7F
// ==================================================
// Field positions in the buffer control registers
`define BUF_CHANNEL_PICK 0
`define BUF_ACCESS_WIDTH 1
`define BUF_XFER_INHIBIT 3
`define BUF_HEAD_PROTECT 4
`define BUF_SPACE_SELECT 5
`define USER_XFER_INHIBIT 1
`define STATUS_BUF_WRITE_MASK 8'h3B
`define USER_BUF_WRITE_MASK 8'h02
// ==================================================
// Reset values and counts
`define FLAGS_RESET 8'h00
`define ENABLES_RESET 8'h00
`define BUF_CTRL_RESET 8'h00
`define PROTECTED_HEAD_BYTES 5'h05
`define SUBCODE_BYTES 10
`define RATIO_SATURATE 8'hFF
// Output master clock ticks per output sample is 256; ratio has 6 fraction bits.
`define RATIO_TICK_SHIFT 2
`endif

// ==== hdl/rx_status_pkg.sv ====
// Types shared by the receiver status register bank.
package rx_status_pkg;
  // One bit per receiver fault, in register bit order.
  typedef struct packed {
    logic spare;
    logic subcode_crc_fault;
    logic status_block_crc_fault;
    logic lock_loss;
    logic sample_usable;
    logic trust_fault;
    logic line_code_fault;
    logic odd_even_check_fail;
  } fault_vec_t;

  // Buffer steering that the rest of the receiver follows.
  typedef struct packed {
    logic buffer_space_select;
    logic status_head_protect;
    logic status_transfer_inhibit;
    logic status_access_width;
    logic channel_pick;
    logic user_transfer_inhibit;
  } buf_ctrl_t;
endpackage

// ==== hdl/rate_ratio_meter.sv ====
// Measures output-to-input sample rate ratio in 2.6 fixed point.
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_defs.svh"
module rate_ratio_meter #(
  parameter int CNT_W = 11
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic master_tick_in,
  input wire logic input_frame_in,
  output logic [7:0] rate_ratio_value_out
);
  // ==================================================
  // Tick counter
  // Counts output master clock ticks over one input sample period.
  logic [CNT_W-1:0] tick_cnt_reg;
  // Saturation level: ratio 4.0 means 1024 ticks per input sample.
  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(1024);

  // The counter sticks at its limit so a very slow input cannot wrap it.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_cnt_reg <= '0;
    end else if (input_frame_in) begin
      tick_cnt_reg <= master_tick_in ? CNT_W'(1) : '0;
    end else if (master_tick_in && tick_cnt_reg != CNT_LIMIT) begin
      tick_cnt_reg <= tick_cnt_reg + CNT_W'(1);
    end
  end

  // ==================================================
  // Ratio register
  // No hysteresis: the low bit follows jitter on either clock.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rate_ratio_value_out <= 8'h00;
    end else if (input_frame_in) begin
      if (tick_cnt_reg >= CNT_LIMIT) begin
        rate_ratio_value_out <= `RATIO_SATURATE;
      end else begin
        rate_ratio_value_out <= tick_cnt_reg[`RATIO_TICK_SHIFT +: 8];
      end
    end
  end

  chk_ratio_saturates: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    input_frame_in && tick_cnt_reg >= CNT_LIMIT |=> rate_ratio_value_out == 8'hFF)
    else $error("Ratio did not saturate.");
endmodule
`default_nettype wire

// ==== hdl/rx_status_regs.sv ====
// Receiver fault flags, buffer control, subcode bytes and rate ratio registers.
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_defs.svh"
module rx_status_regs (
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register access from the control port.
  input wire logic [6:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Raw fault sources from the receiver.
  input wire rx_status_pkg::fault_vec_t fault_raw_in,
  input wire logic professional_in,
  input wire logic subframe_boundary_in,
  input wire logic status_block_boundary_in,
  input wire logic subcode_block_boundary_in,
  output logic receiver_fault_output_out,
  output logic receiver_fault_irq_src_out,
  output logic sample_hold_request_out,
  // Buffer management.
  output rx_status_pkg::buf_ctrl_t buf_ctrl_out,
  input wire logic status_xfer_req_in,
  input wire logic status_xfer_busy_in,
  output logic status_xfer_allow_out,
  output logic status_transfer_event_out,
  input wire logic user_block_mode_in,
  input wire logic user_xfer_req_in,
  input wire logic user_xfer_busy_in,
  output logic user_xfer_allow_out,
  output logic user_transfer_event_out,
  input wire logic status_e_write_in,
  input wire logic [4:0] status_e_index_in,
  output logic status_e_write_out,
  // Channel A and B sources steered by channel pick; the buffer byte follows it in one-byte mode only.
  input wire logic preemph_a_n_in,
  input wire logic preemph_b_n_in,
  output logic preemphasis_indicator_n_out,
  input wire logic [7:0] summary_a_in,
  input wire logic [7:0] summary_b_in,
  output logic [7:0] summary_out,
  input wire logic [7:0] buf_byte_a_in,
  input wire logic [7:0] buf_byte_b_in,
  output logic [7:0] buf_byte_out,
  // Subcode and rate inputs.
  input wire logic [79:0] subcode_bits_in,
  input wire logic subcode_load_in,
  input wire logic master_tick_in,
  input wire logic input_frame_in
);
  import rx_status_pkg::*;

  // ==================================================
  // Storage
  fault_vec_t src_reg; // Refreshed fault sources.
  fault_vec_t flags_reg; // Sticky fault flags.
  logic [7:0] enables_reg; // Fault enables, 1 unmasks.
  logic [7:0] status_ctrl_reg; // Status buffer control.
  logic [7:0] user_ctrl_reg; // User buffer control.
  logic [7:0] subcode_reg [`SUBCODE_BYTES]; // Decoded subcode bytes.
  logic [7:0] ratio_value; // Rate ratio from the meter.
  logic [7:0] src_on; // Enabled and active sources.
  logic flags_read; // Host reads the flag register.

  assign flags_read = reg_read_in && reg_addr_in == `FAULT_FLAGS_ADDR;
  assign src_on = src_reg & enables_reg & `FLT_WRITE_MASK;

  // ==================================================
  // Fault source refresh
  // Each source is sampled only at its own boundary, so the flag
  // reflects the state at that boundary and not glitches between.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_reg <= '0;
    end else begin
      if (subframe_boundary_in) begin
        src_reg.odd_even_check_fail <= fault_raw_in.odd_even_check_fail;
        src_reg.line_code_fault <= fault_raw_in.line_code_fault;
        src_reg.sample_usable <= fault_raw_in.sample_usable;
        // Trust uses the raw lock state so both halves are current.
        src_reg.trust_fault <= fault_raw_in.line_code_fault
                               | fault_raw_in.lock_loss;
      end
      if (status_block_boundary_in) begin
        src_reg.lock_loss <= fault_raw_in.lock_loss;
        // Consumer blocks carry no CRC, so the check means nothing there.
        src_reg.status_block_crc_fault <= fault_raw_in.status_block_crc_fault
                                          & professional_in;
      end
      if (subcode_block_boundary_in) begin
        src_reg.subcode_crc_fault <= fault_raw_in.subcode_crc_fault;
      end
    end
  end

  // ==================================================
  // Sticky flags
  // A read restarts the flags from the still-active sources in the same
  // edge, so a fault arriving during the read survives into the next one.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_reg <= `FLAGS_RESET;
    end else if (flags_read) begin
      flags_reg <= src_on;
    end else begin
      flags_reg <= (flags_reg & enables_reg) | src_on;
    end
  end

  // ==================================================
  // Control registers
  // Only documented bits are stored; the others stay zero.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enables_reg <= `ENABLES_RESET;
      status_ctrl_reg <= `BUF_CTRL_RESET;
      user_ctrl_reg <= `BUF_CTRL_RESET;
    end else if (reg_write_in) begin
      unique case (reg_addr_in)
        `FAULT_ENABLES_ADDR: begin
          enables_reg <= reg_wdata_in & `FLT_WRITE_MASK;
        end
        `STATUS_BUF_CTRL_ADDR: begin
          status_ctrl_reg <= reg_wdata_in & `STATUS_BUF_WRITE_MASK;
        end
        `USER_BUF_CTRL_ADDR: begin
          user_ctrl_reg <= reg_wdata_in & `USER_BUF_WRITE_MASK;
        end
        default: begin
          // Writes elsewhere hit read-only or unmapped space and are dropped.
        end
      endcase
    end
  end

  // ==================================================
  // Subcode bytes
  // Byte k holds Q[8k] in bit 7 down to Q[8k+7] in bit 0.
  genvar gi;
  generate
    for (gi = 0; gi < `SUBCODE_BYTES; gi++) begin : g_subcode
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          subcode_reg[gi] <= 8'h00;
        end else if (subcode_load_in) begin
          subcode_reg[gi] <= {<<{subcode_bits_in[gi*8 +: 8]}};
        end
      end
    end
  endgenerate

  // ==================================================
  // Rate ratio
  // The host must wait for lock before trusting this value.
  rate_ratio_meter u_ratio (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .master_tick_in(master_tick_in),
    .input_frame_in(input_frame_in),
    .rate_ratio_value_out(ratio_value)
  );

  // ==================================================
  // Read port
  // Data appears one cycle after the read strobe, with a valid pulse.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_read_in;
      if (reg_read_in) begin
        if (reg_addr_in >= `SUBCODE_FIRST_ADDR && reg_addr_in <= `SUBCODE_LAST_ADDR) begin
          reg_rdata_out <= subcode_reg[4'(reg_addr_in - `SUBCODE_FIRST_ADDR)];
        end else begin
          unique case (reg_addr_in)
            `FAULT_FLAGS_ADDR: begin
              reg_rdata_out <= flags_reg & enables_reg;
            end
            `FAULT_ENABLES_ADDR: begin
              reg_rdata_out <= enables_reg;
            end
            `STATUS_BUF_CTRL_ADDR: begin
              reg_rdata_out <= status_ctrl_reg;
            end
            `USER_BUF_CTRL_ADDR: begin
              reg_rdata_out <= user_ctrl_reg;
            end
            `RATE_RATIO_ADDR: begin
              reg_rdata_out <= ratio_value;
            end
            default: begin
              // Unmapped addresses answer zero.
              reg_rdata_out <= 8'h00;
            end
          endcase
        end
      end
    end
  end

  // ==================================================
  // Fault outputs
  // Pin and interrupt source follow enabled active sources as levels.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      receiver_fault_output_out <= 1'b0;
      receiver_fault_irq_src_out <= 1'b0;
      sample_hold_request_out <= 1'b0;
    end else begin
      receiver_fault_output_out <= |src_on;
      receiver_fault_irq_src_out <= |src_on;
      // CRC faults are excluded: they arrive a block late.
      sample_hold_request_out <= |(src_on & `FLT_SAMPLE_MASK);
    end
  end

  // ==================================================
  // Buffer steering
  always_comb begin
    buf_ctrl_out.buffer_space_select = status_ctrl_reg[`BUF_SPACE_SELECT];
    buf_ctrl_out.status_head_protect = status_ctrl_reg[`BUF_HEAD_PROTECT];
    buf_ctrl_out.status_transfer_inhibit = status_ctrl_reg[`BUF_XFER_INHIBIT];
    buf_ctrl_out.status_access_width = status_ctrl_reg[`BUF_ACCESS_WIDTH];
    buf_ctrl_out.channel_pick = status_ctrl_reg[`BUF_CHANNEL_PICK];
    buf_ctrl_out.user_transfer_inhibit = user_ctrl_reg[`USER_XFER_INHIBIT];
  end

  // Transfer gating is combinational so the buffer engine sees it at once.
  assign status_xfer_allow_out = status_xfer_req_in
                                 && !buf_ctrl_out.status_transfer_inhibit;
  // Outside block mode the user inhibit has no effect.
  assign user_xfer_allow_out = user_xfer_req_in
      && !(buf_ctrl_out.user_transfer_inhibit && user_block_mode_in);
  assign status_transfer_event_out = status_xfer_busy_in;
  assign user_transfer_event_out = user_xfer_busy_in && user_block_mode_in;
  assign status_e_write_out = status_e_write_in
      && !(buf_ctrl_out.status_head_protect
           && status_e_index_in < `PROTECTED_HEAD_BYTES);

  // ==================================================
  // Channel-steered outputs
  // Preemphasis and summary follow channel pick; the buffer byte is channel A in two-byte mode and the picked channel in one-byte mode.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      preemphasis_indicator_n_out <= 1'b1;
      summary_out <= 8'h00;
      buf_byte_out <= 8'h00;
    end else begin
      preemphasis_indicator_n_out <= buf_ctrl_out.channel_pick
                                     ? preemph_b_n_in : preemph_a_n_in;
      summary_out <= buf_ctrl_out.channel_pick ? summary_b_in : summary_a_in;
      if (!buf_ctrl_out.status_access_width && buf_ctrl_out.channel_pick) begin
        buf_byte_out <= buf_byte_b_in;
      end else begin
        buf_byte_out <= buf_byte_a_in;
      end
    end
  end

  // ==================================================
  // Checks
  sequence s_flag_read;
    flags_read;
  endsequence

  sequence s_flag_answer;
    reg_rvalid_out && reg_rdata_out == ($past(flags_reg) & $past(enables_reg));
  endsequence

  chk_read_returns_flags: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    s_flag_read |=> s_flag_answer)
    else $error("Flag read returned wrong data.");

  chk_read_keeps_active: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    s_flag_read |=> flags_reg == $past(src_on))
    else $error("Read did not restart flags from active sources.");

  chk_masked_reads_zero: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    reg_rvalid_out && $past(flags_read) |-> (reg_rdata_out & ~$past(enables_reg)) == 8'h00)
    else $error("Masked flag bit read as one.");

  chk_flag_sticks: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    flags_reg.odd_even_check_fail && enables_reg[`FLT_ODD_EVEN] && !flags_read
    |=> flags_reg.odd_even_check_fail)
    else $error("Sticky flag dropped without a read.");

  chk_trust_is_or: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    subframe_boundary_in |=> src_reg.trust_fault ==
      ($past(fault_raw_in.line_code_fault) | $past(fault_raw_in.lock_loss)))
    else $error("Trust fault is not line code OR lock loss.");

  chk_crc_no_hold: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (src_on & `FLT_SAMPLE_MASK) == 8'h00 |=> !sample_hold_request_out)
    else $error("CRC fault held the audio sample.");

  chk_head_protect: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    buf_ctrl_out.status_head_protect && status_e_index_in < 5'h05 |-> !status_e_write_out)
    else $error("Protected status byte was overwritten.");

  chk_status_inhibit: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    buf_ctrl_out.status_transfer_inhibit |-> !status_xfer_allow_out)
    else $error("Inhibited status transfer was allowed.");

  chk_pin_follows: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    src_on == 8'h00 |=> !receiver_fault_output_out && !receiver_fault_irq_src_out)
    else $error("Fault output raised with nothing enabled.");
endmodule
`default_nettype wire

// ==== test/rx_host_model.sv ====
// Host controller model that drives the register strobe port of the status bank.
`timescale 1ns/1ps
`default_nettype none
module rx_host_model (
  input wire logic clk_in,
  output logic [6:0] reg_addr_out,
  output logic reg_write_out,
  output logic reg_read_out,
  output logic [7:0] reg_wdata_out
);
  // ==========
  // Bus idle state
  // The bus starts idle, with no strobe and address and data parked.
  initial begin
    reg_addr_out = 7'h00;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // One strobe cycle launched off the falling edge. Address and data are turned over afterwards
  // so that a design that samples late cannot see a stale value by luck.
  task automatic access(input logic [6:0] addr, input logic [7:0] data, input logic wr);
    @(negedge clk_in);
    reg_addr_out = addr;
    reg_wdata_out = data;
    reg_write_out = wr;
    reg_read_out = ~wr;
    @(negedge clk_in);
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    reg_addr_out = ~addr;
    reg_wdata_out = ~data;
  endtask
  // Write one byte.
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    access(addr, data, 1'b1);
  endtask
  // Read one byte; the data comes back with the valid pulse.
  task automatic rd(input logic [6:0] addr);
    access(addr, 8'h00, 1'b0);
  endtask
endmodule
`default_nettype wire

// ==== test/digital_audio_rx_status_regs_tb_top.sv ====
// Self-checking bench for the receiver status register bank.
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_defs.svh"
module digital_audio_rx_status_regs_tb_top;
  import rx_status_pkg::*;
  logic clk_in, reset_n_in, reg_write_in, reg_read_in, reg_rvalid_out;
  logic [6:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, e;
  fault_vec_t fault_raw_in;
  buf_ctrl_t buf_ctrl_out;
  logic professional_in, subframe_boundary_in, status_block_boundary_in;
  logic subcode_block_boundary_in, receiver_fault_output_out, receiver_fault_irq_src_out;
  logic sample_hold_request_out, status_xfer_req_in, status_xfer_busy_in;
  logic status_xfer_allow_out, status_transfer_event_out, user_block_mode_in;
  logic user_xfer_req_in, user_xfer_busy_in, user_xfer_allow_out, user_transfer_event_out;
  logic status_e_write_in, status_e_write_out, preemph_a_n_in, preemph_b_n_in;
  logic preemphasis_indicator_n_out, subcode_load_in, master_tick_in, input_frame_in;
  logic [4:0] status_e_index_in;
  logic [7:0] summary_a_in, summary_b_in, summary_out, buf_byte_a_in, buf_byte_b_in, buf_byte_out;
  logic [79:0] subcode_bits_in;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 32'h7FF3;
  int gap[3] = '{130, 258, 1100};
  logic [7:0] rr[3] = '{8'h20, 8'h40, 8'hFF};
  rx_status_regs dut (.clk_in, .reset_n_in, .reg_addr_in, .reg_write_in, .reg_read_in,
    .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .fault_raw_in, .professional_in,
    .subframe_boundary_in, .status_block_boundary_in, .subcode_block_boundary_in,
    .receiver_fault_output_out, .receiver_fault_irq_src_out, .sample_hold_request_out,
    .buf_ctrl_out, .status_xfer_req_in, .status_xfer_busy_in, .status_xfer_allow_out,
    .status_transfer_event_out, .user_block_mode_in, .user_xfer_req_in, .user_xfer_busy_in,
    .user_xfer_allow_out, .user_transfer_event_out, .status_e_write_in, .status_e_index_in,
    .status_e_write_out, .preemph_a_n_in, .preemph_b_n_in, .preemphasis_indicator_n_out,
    .summary_a_in, .summary_b_in, .summary_out, .buf_byte_a_in, .buf_byte_b_in, .buf_byte_out,
    .subcode_bits_in, .subcode_load_in, .master_tick_in, .input_frame_in);
  rx_host_model host (.clk_in, .reg_addr_out(reg_addr_in), .reg_write_out(reg_write_in),
    .reg_read_out(reg_read_in), .reg_wdata_out(reg_wdata_in));
  // ==========
  // Clock, timeout and read monitor
  // The 8 ns clock; the timeout guards against a run that never reaches results.
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      $display("ERROR timeout expected 0 seen 1");
      results();
    end
  end
  // Each read answer retires the oldest expectation; sampled mid-cycle, where it is settled.
  always @(negedge clk_in) begin
    if (reg_rvalid_out === 1'b1) begin
      if (exp_q.size() == 0) cmp("unexpected rvalid", 8'h00, 8'h01);
      else cmp("rdata", exp_q.pop_front(), reg_rdata_out);
    end
  end
  // ==========
  // Shared tasks
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pin(input string what, input logic got, input logic exp);
    cmp(what, {7'h00, exp}, {7'h00, got});
  endtask
  // Note the expected byte, then let the host read it.
  task automatic rx(input logic [6:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    host.rd(a);
  endtask
  // Boundary pulses: bit 0 sub-frame, bit 1 status block, bit 2 subcode block.
  task automatic pb(input logic [2:0] m);
    @(negedge clk_in);
    {subcode_block_boundary_in, status_block_boundary_in, subframe_boundary_in} = m;
    @(negedge clk_in);
    {subcode_block_boundary_in, status_block_boundary_in, subframe_boundary_in} = 3'b000;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic done(input string name);
    repeat (3) @(negedge clk_in);
    if (exp_q.size() != 0) cmp("pending reads", 8'h00, 8'(exp_q.size()));
    $display("Test %s finished", name);
  endtask
  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    reset_n_in = 1'b0;
    fault_raw_in = '0;
    {professional_in, subframe_boundary_in, status_block_boundary_in} = 3'b000;
    {subcode_block_boundary_in, status_xfer_req_in, status_xfer_busy_in} = 3'b000;
    {user_block_mode_in, user_xfer_req_in, user_xfer_busy_in, status_e_write_in} = 4'h0;
    {preemph_a_n_in, preemph_b_n_in, subcode_load_in, input_frame_in} = 4'hC;
    {status_e_index_in, summary_a_in, summary_b_in} = '0;
    {buf_byte_a_in, buf_byte_b_in, subcode_bits_in} = '0;
    // The master clock ticks once per cycle, so a gap of N cycles is N ticks.
    master_tick_in = 1'b1;
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'b1;
    rx(`FAULT_FLAGS_ADDR, 8'h00);
    rx(`FAULT_ENABLES_ADDR, 8'h00);
    rx(`STATUS_BUF_CTRL_ADDR, 8'h00);
    rx(`USER_BUF_CTRL_ADDR, 8'h00);
    rx(7'h05, 8'h00);
    host.wr(`FAULT_FLAGS_ADDR, 8'hFF);
    rx(`FAULT_FLAGS_ADDR, 8'h00);
    host.wr(`FAULT_ENABLES_ADDR, 8'hFF);
    rx(`FAULT_ENABLES_ADDR, 8'h7F);
    host.wr(`STATUS_BUF_CTRL_ADDR, 8'hFF);
    rx(`STATUS_BUF_CTRL_ADDR, 8'h3B);
    host.wr(`USER_BUF_CTRL_ADDR, 8'hFF);
    rx(`USER_BUF_CTRL_ADDR, 8'h02);
    done("registers");
    // All buffer controls set: inhibits, head protect, two-byte mode, channel B.
    cmp("buf_ctrl", 8'h3F, {2'b00, buf_ctrl_out});
    {status_xfer_req_in, user_xfer_req_in, user_block_mode_in} = 3'b111;
    {status_xfer_busy_in, user_xfer_busy_in, status_e_write_in} = 3'b111;
    status_e_index_in = 5'h04;
    summary_a_in = 8'($random(seed));
    summary_b_in = ~summary_a_in;
    buf_byte_a_in = 8'($random(seed));
    buf_byte_b_in = ~buf_byte_a_in;
    {preemph_a_n_in, preemph_b_n_in} = 2'b10;
    repeat (3) @(negedge clk_in);
    pin("status_allow", status_xfer_allow_out, 1'b0);
    pin("user_allow", user_xfer_allow_out, 1'b0);
    pin("head_write", status_e_write_out, 1'b0);
    pin("status_event", status_transfer_event_out, 1'b1);
    pin("user_event", user_transfer_event_out, 1'b1);
    pin("preemphasis_indicator_n", preemphasis_indicator_n_out, 1'b0);
    cmp("summary", summary_b_in, summary_out);
    cmp("buf_byte", buf_byte_a_in, buf_byte_out);
    status_e_index_in = 5'h05;
    user_block_mode_in = 1'b0;
    #1;
    pin("tail_write", status_e_write_out, 1'b1);
    pin("user_allow", user_xfer_allow_out, 1'b1);
    pin("user_event", user_transfer_event_out, 1'b0);
    host.wr(`STATUS_BUF_CTRL_ADDR, 8'h01);
    status_e_index_in = 5'h00;
    repeat (3) @(negedge clk_in);
    pin("status_allow", status_xfer_allow_out, 1'b1);
    pin("head_write", status_e_write_out, 1'b1);
    cmp("buf_byte", buf_byte_b_in, buf_byte_out);
    host.wr(`STATUS_BUF_CTRL_ADDR, 8'h00);
    repeat (3) @(negedge clk_in);
    cmp("summary", summary_a_in, summary_out);
    pin("preemphasis_indicator_n", preemphasis_indicator_n_out, 1'b1);
    done("buffers");
    // A second reset in mid-run, then the sticky fault flags.
    @(negedge clk_in);
    reset_n_in = 1'b0;
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'b1;
    host.wr(`FAULT_ENABLES_ADDR, 8'h7F);
    fault_raw_in.odd_even_check_fail = 1'b1;
    pb(3'b001);
    fault_raw_in = '0;
    pb(3'b001);
    rx(`FAULT_FLAGS_ADDR, 8'h01);
    rx(`FAULT_FLAGS_ADDR, 8'h00);
    fault_raw_in.line_code_fault = 1'b1;
    pb(3'b001);
    rx(`FAULT_FLAGS_ADDR, 8'h06);
    rx(`FAULT_FLAGS_ADDR, 8'h06);
    pin("hold", sample_hold_request_out, 1'b1);
    fault_raw_in = '0;
    fault_raw_in.sample_usable = 1'b1;
    pb(3'b001);
    rx(`FAULT_FLAGS_ADDR, 8'h0E);
    rx(`FAULT_FLAGS_ADDR, 8'h08);
    fault_raw_in = '0;
    fault_raw_in.lock_loss = 1'b1;
    pb(3'b001);
    rx(`FAULT_FLAGS_ADDR, 8'h0C);
    pb(3'b010);
    rx(`FAULT_FLAGS_ADDR, 8'h14);
    fault_raw_in.status_block_crc_fault = 1'b1;
    pb(3'b010);
    rx(`FAULT_FLAGS_ADDR, 8'h14);
    professional_in = 1'b1;
    pb(3'b010);
    rx(`FAULT_FLAGS_ADDR, 8'h34);
    fault_raw_in = '0;
    fault_raw_in.subcode_crc_fault = 1'b1;
    pb(3'b111);
    rx(`FAULT_FLAGS_ADDR, 8'h74);
    pin("hold", sample_hold_request_out, 1'b0);
    pin("fault_pin", receiver_fault_output_out, 1'b1);
    rx(`FAULT_FLAGS_ADDR, 8'h40);
    host.wr(`FAULT_ENABLES_ADDR, 8'h01);
    rx(`FAULT_FLAGS_ADDR, 8'h00);
    pin("fault_pin", receiver_fault_output_out, 1'b0);
    fault_raw_in.odd_even_check_fail = 1'b1;
    pb(3'b001);
    pin("irq_src", receiver_fault_irq_src_out, 1'b1);
    rx(`FAULT_FLAGS_ADDR, 8'h01);
    done("faults");
    // Subcode bytes come back least bit first, first bit in bit 7.
    subcode_bits_in[31:0] = $random(seed);
    subcode_bits_in[63:32] = $random(seed);
    subcode_bits_in[79:64] = 16'($random(seed));
    @(negedge clk_in);
    subcode_load_in = 1'b1;
    @(negedge clk_in);
    subcode_load_in = 1'b0;
    for (int k = 0; k < `SUBCODE_BYTES; k++) begin
      for (int i = 0; i < 8; i++) e[7 - i] = subcode_bits_in[8 * k + i];
      rx(7'(`SUBCODE_FIRST_ADDR + k), e);
    end
    done("subcode");
    // The host reads the ratio only while the loop reports lock.
    // Unmask only lock loss and confirm the loop is locked before the ratio reads.
    fault_raw_in = '0;
    host.wr(`FAULT_ENABLES_ADDR, 8'h10);
    pb(3'b010);
    rx(`FAULT_FLAGS_ADDR, 8'h00);
    for (int t = 0; t < 3; t++) begin
      repeat (3) begin
        @(negedge clk_in);
        input_frame_in = 1'b1;
        @(negedge clk_in);
        input_frame_in = 1'b0;
        repeat (gap[t] - 2) @(negedge clk_in);
      end
      rx(`RATE_RATIO_ADDR, rr[t]);
    end
    done("ratio");
    results();
  end
endmodule
`default_nettype wire
